// ===== spisp_top.v
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "spisp_defines.vh"
module spisp_top #(
    parameter [5:0] DIV4_HALF = `SPISP_DIV4_HALF,
    parameter [5:0] DIV16_HALF = `SPISP_DIV16_HALF,
    parameter [5:0] DIV64_HALF = `SPISP_DIV64_HALF
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe,
    input wire sdi_in,
    output reg sdo_out,
    output reg sdo_oe,
    input wire ss_n_in,
    output reg ss_n_out,
    output reg ss_n_oe,
    input wire sub_clk_in,
    input wire timer_match,
    output reg xfer_irq
);

// unit control state
reg [2:0] unit_mode_field;
reg serial_unit_enable;
reg incomplete_transfer_flag;
// spi control state
reg [1:0] spare_bits;
reg clock_idle_low_sel;
reg capture_edge_sel;
reg msb_first_sel;
reg select_pin_enable;
reg write_collision_flag;
reg transfer_done_flag;
// shifter and sequencing
reg [7:0] shift_data_reg;
reg running;
reg running_d;
reg [3:0] half_cnt;
reg [3:0] bit_cnt;
reg [5:0] div_cnt;
reg act_idle_low;
reg act_cap_edge;
// bus slave state
reg aw_got;
reg w_got;
reg [7:0] aw_addr_q;
reg [31:0] w_data_q;
reg w_strb0_q;
// delayed copies of synchronised pins for edge finding
reg sck_d;
reg ss_d;
reg sub_d;

wire [3:0] pin_sync;
wire sub_s = pin_sync[3];
wire sck_s = pin_sync[2];
wire ss_n_s = pin_sync[1];
wire sdi_s = pin_sync[0];

// true when an edge of the given direction is the capture edge
function is_cap;
    input rise;
    input idle_low;
    input cap_edge;
    begin
        is_cap = rise ? (idle_low ~^ cap_edge) : (idle_low ^ cap_edge);
    end
endfunction

// bit that leaves the shifter next
function out_bit;
    input [7:0] d;
    input msb;
    begin
        out_bit = msb ? d[7] : d[0];
    end
endfunction

// shift one received bit in from the side opposite the outgoing bit
function [7:0] shift_in;
    input [7:0] d;
    input b;
    input msb;
    begin
        shift_in = msb ? {d[6:0], b} : {b, d[7:1]};
    end
endfunction

// register index from a byte address; 2'd3 means unmapped
function [1:0] reg_sel;
    input [7:0] addr;
    begin
        if ({addr[7:2], 2'b00} == `SPISP_OFF_UNIT_CTRL)
            reg_sel = 2'd0;
        else if ({addr[7:2], 2'b00} == `SPISP_OFF_SPI_CTRL)
            reg_sel = 2'd1;
        else if ({addr[7:2], 2'b00} == `SPISP_OFF_SHIFT_DATA)
            reg_sel = 2'd2;
        else
            reg_sel = 2'd3;
    end
endfunction

// pins come from outside the clock domain
spisp_sync #(
    .WIDTH(4)
) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({sub_clk_in, sck_in, ss_n_in, sdi_in}),
    .sync_out(pin_sync)
);

// mode decode; i2c and none codes leave the spi idle
wire is_master = serial_unit_enable && (unit_mode_field <= `SPISP_MODE_TIMER); // R16 R17
wire is_slave = serial_unit_enable && (unit_mode_field == `SPISP_MODE_SLAVE); // R16 R17

// half-period tick of the master clock from the selected source
reg div_hit;
always @* begin
    div_hit = 1'b0;
    case (unit_mode_field)
        `SPISP_MODE_DIV4: div_hit = (div_cnt == DIV4_HALF - 6'd1);
        `SPISP_MODE_DIV16: div_hit = (div_cnt == DIV16_HALF - 6'd1);
        `SPISP_MODE_DIV64: div_hit = (div_cnt == DIV64_HALF - 6'd1);
        `SPISP_MODE_SUB: div_hit = sub_s ^ sub_d;
        `SPISP_MODE_TIMER: div_hit = timer_match;
        default: div_hit = 1'b0;
    endcase
end

// no edge in the first running cycle so the select leads the clock;
// the tick needs running and running_d as well as a hit from the chosen source
wire half_tick = running && running_d && div_hit; // R14
wire m_cap = half_tick && is_cap(~sck_out, act_idle_low, act_cap_edge); // R2
wire m_launch = half_tick && !m_cap;

// slave side: select gating and edges of the synchronised clock
wire s_sel = !select_pin_enable || !ss_n_s; // R4 R11
wire s_rise = sck_s && !sck_d;
wire s_fall = !sck_s && sck_d;
wire s_edge = is_slave && s_sel && (s_rise || s_fall);
wire s_cap = s_edge && is_cap(s_rise, act_idle_low, act_cap_edge); // R2 R10
wire s_launch = s_edge && !s_cap; // R13
wire s_abort = is_slave && select_pin_enable && ss_n_s && !ss_d
    && (bit_cnt != 4'd0); // R18

// a slave capture in the same cycle counts as busy, so a load it would overwrite is refused with a collision
wire busy = running || (bit_cnt != 4'd0) || s_cap; // R5

// bus handshake next values
wire b_done = s_axi_bvalid && s_axi_bready;
wire next_aw_got = aw_got ? !b_done : (s_axi_awvalid && s_axi_awready);
wire next_w_got = w_got ? !b_done : (s_axi_wvalid && s_axi_wready);
wire next_rvalid = s_axi_rvalid ? !s_axi_rready : (s_axi_arvalid && s_axi_arready);
wire wr_do = aw_got && w_got && !s_axi_bvalid;
wire [1:0] wr_sel = reg_sel(aw_addr_q);
wire [1:0] rd_sel = reg_sel(s_axi_araddr);

// axi4-lite slave: address and data taken in either order, one at a time
always @(posedge ref_clk) begin
    if (sys_rst) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        aw_addr_q <= 8'h00;
        w_data_q <= 32'h00000000;
        w_strb0_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SPISP_RESP_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `SPISP_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
    end else begin
        aw_got <= next_aw_got;
        w_got <= next_w_got;
        s_axi_awready <= !next_aw_got;
        s_axi_wready <= !next_w_got;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
        end
        if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == 2'd3) ? `SPISP_RESP_SLVERR : `SPISP_RESP_OKAY;
        end else if (b_done) begin
            s_axi_bvalid <= 1'b0;
        end
        s_axi_rvalid <= next_rvalid;
        s_axi_arready <= !next_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rresp <= (rd_sel == 2'd3) ? `SPISP_RESP_SLVERR : `SPISP_RESP_OKAY;
            case (rd_sel)
                2'd0: s_axi_rdata <= {24'h000000, unit_mode_field, 1'b0, 2'b00,
                    serial_unit_enable, incomplete_transfer_flag};
                2'd1: s_axi_rdata <= {24'h000000, spare_bits, clock_idle_low_sel,
                    capture_edge_sel, msb_first_sel, select_pin_enable,
                    write_collision_flag, transfer_done_flag}; // R15
                2'd2: s_axi_rdata <= {24'h000000, shift_data_reg};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end
    end
end

// register file, shifter and transfer sequencing; hardware sets are
// written after software clears so a set in the same cycle wins
always @(posedge ref_clk) begin
    if (sys_rst) begin
        unit_mode_field <= `SPISP_UC_MODE_RST;
        serial_unit_enable <= 1'b0;
        incomplete_transfer_flag <= 1'b0;
        {spare_bits, clock_idle_low_sel, capture_edge_sel, msb_first_sel,
            select_pin_enable, write_collision_flag, transfer_done_flag} <= `SPISP_SC_RST;
        shift_data_reg <= 8'h00;
        running <= 1'b0;
        running_d <= 1'b0;
        half_cnt <= 4'h0;
        bit_cnt <= 4'h0;
        div_cnt <= 6'h00;
        act_idle_low <= 1'b0;
        act_cap_edge <= 1'b0;
        sck_d <= 1'b0;
        ss_d <= 1'b0;
        sub_d <= 1'b0;
    end else begin
        sck_d <= sck_s;
        ss_d <= ss_n_s;
        sub_d <= sub_s;
        running_d <= running;
        // clock settings only follow software between transfers
        if (!busy) begin
            act_idle_low <= clock_idle_low_sel; // R12
            act_cap_edge <= capture_edge_sel; // R12
        end
        // software writes
        if (wr_do && w_strb0_q) begin
            case (wr_sel)
                2'd0: begin
                    unit_mode_field <= w_data_q[`SPISP_UC_MODE_LSB+2:`SPISP_UC_MODE_LSB];
                    serial_unit_enable <= w_data_q[`SPISP_UC_EN_BIT];
                    // a software set stays here and never reaches the done flag
                    incomplete_transfer_flag <= w_data_q[`SPISP_UC_ICF_BIT]; // R19
                end
                2'd1: begin
                    spare_bits <= w_data_q[`SPISP_SC_SPARE_LSB+1:`SPISP_SC_SPARE_LSB]; // R15
                    clock_idle_low_sel <= w_data_q[`SPISP_SC_IDLE_LOW_BIT];
                    capture_edge_sel <= w_data_q[`SPISP_SC_CAP_EDGE_BIT];
                    msb_first_sel <= w_data_q[`SPISP_SC_MSB_BIT];
                    select_pin_enable <= w_data_q[`SPISP_SC_SEL_EN_BIT];
                    // flags: writing zero clears, writing one leaves them
                    if (!w_data_q[`SPISP_SC_WRITE_COLLISION_FLAG_BIT])
                        write_collision_flag <= 1'b0; // R6
                    if (!w_data_q[`SPISP_SC_TRF_BIT])
                        transfer_done_flag <= 1'b0; // R7
                end
                2'd2: begin
                    if (busy) begin
                        write_collision_flag <= 1'b1; // R5
                    end else begin
                        shift_data_reg <= w_data_q[7:0];
                        if (is_master) begin
                            running <= 1'b1; // R9
                            half_cnt <= 4'h0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // divider restarts with every transfer so the first half is full
        if (!running || div_hit)
            div_cnt <= 6'h00;
        else
            div_cnt <= div_cnt + 6'd1;
        // master: toggle the clock, capture on one edge, launch on the other
        if (half_tick) begin
            half_cnt <= half_cnt + 4'd1;
            if (m_cap)
                shift_data_reg <= shift_in(shift_data_reg, sdi_s, msb_first_sel); // R3 R9
            if (half_cnt == {`SPISP_XFER_BITS, 1'b0} - 5'd1) begin
                running <= 1'b0;
                transfer_done_flag <= 1'b1; // R7 R20
            end
        end
        // leaving master mode or disabling the unit aborts quietly
        if (!is_master)
            running <= 1'b0; // R17
        // slave: count captured bits, done after a full byte
        if (s_cap) begin
            shift_data_reg <= shift_in(shift_data_reg, sdi_s, msb_first_sel); // R3 R10
            if (bit_cnt == `SPISP_XFER_BITS - 4'd1) begin
                bit_cnt <= 4'h0;
                transfer_done_flag <= 1'b1; // R7 R20
            end else begin
                bit_cnt <= bit_cnt + 4'd1;
            end
        end else if (!is_slave || !s_sel) begin
            bit_cnt <= 4'h0;
        end
        // early deselect flags both the incomplete and the done state
        if (s_abort) begin
            incomplete_transfer_flag <= 1'b1; // R18
            transfer_done_flag <= 1'b1; // R18
        end
    end
end

// pin drivers, all registered; disabled unit releases every pin
always @(posedge ref_clk) begin
    if (sys_rst) begin
        sck_out <= 1'b1;
        sck_oe <= 1'b0;
        sdo_out <= 1'b0;
        sdo_oe <= 1'b0;
        ss_n_out <= 1'b1;
        ss_n_oe <= 1'b0;
        xfer_irq <= 1'b0;
    end else begin
        // idle level follows the select bit whenever no clock runs
        if (!running)
            sck_out <= !clock_idle_low_sel; // R1
        else if (half_tick)
            sck_out <= !sck_out;
        sck_oe <= is_master; // R17
        // outgoing bit: preset on load, refreshed on each launch edge
        if (wr_do && w_strb0_q && (wr_sel == 2'd2) && !busy)
            sdo_out <= out_bit(w_data_q[7:0], msb_first_sel); // R3
        else if (m_launch || s_launch)
            sdo_out <= out_bit(shift_data_reg, msb_first_sel); // R13
        sdo_oe <= is_master || (is_slave && s_sel); // R17
        // select held two cycles past the last edge; floats when disabled
        ss_n_out <= !(running || running_d);
        ss_n_oe <= is_master && select_pin_enable; // R4
        xfer_irq <= transfer_done_flag; // R8
    end
end

endmodule // spisp_top

// ===== spisp_defines.vh
// Functional notes
// R1: idle clock level: bit 0 high, 1 low
// R2: capture edge chosen by idle level and bit
// R3: bit order select: 0 lsb first, 1 msb
// R4: select pin floats unless enable bit set
// R5: data write during transfer dropped, collision set
// R6: collision flag cleared only by software zero
// R7: done flag set by hardware, software clears
// R8: done flag drives interrupt request output
// R9: master data write starts full duplex exchange
// R10: slave shifts data out and in together
// R11: external master asserts select before clocking
// R12: clock settings fixed before transfer starts
// R13: slave output bit timed by clock settings
// R14: master runs whenever chosen clock source runs
// R15: two spare control bits store and return
// R16: mode field picks master clock, slave, none
// R17: unit disable releases pins, keeps settings
// R18: slave deselect midway sets incomplete and done
// R19: software incomplete set never sets done
// R20: every transfer moves exactly eight bits
`ifndef SPISP_DEFINES_VH
`define SPISP_DEFINES_VH

// register byte offsets
`define SPISP_OFF_UNIT_CTRL 8'h00
`define SPISP_OFF_SPI_CTRL 8'h04
`define SPISP_OFF_SHIFT_DATA 8'h08

// unit control fields
`define SPISP_UC_MODE_LSB 5
`define SPISP_UC_EN_BIT 1
`define SPISP_UC_ICF_BIT 0
`define SPISP_UC_MODE_RST 3'b111

// spi control fields
`define SPISP_SC_SPARE_LSB 6
`define SPISP_SC_IDLE_LOW_BIT 5
`define SPISP_SC_CAP_EDGE_BIT 4
`define SPISP_SC_MSB_BIT 3
`define SPISP_SC_SEL_EN_BIT 2
`define SPISP_SC_WRITE_COLLISION_FLAG_BIT 1
`define SPISP_SC_TRF_BIT 0
`define SPISP_SC_RST 8'h00

// unit mode codes
`define SPISP_MODE_DIV4 3'b000
`define SPISP_MODE_DIV16 3'b001
`define SPISP_MODE_DIV64 3'b010
`define SPISP_MODE_SUB 3'b011
`define SPISP_MODE_TIMER 3'b100
`define SPISP_MODE_SLAVE 3'b101
`define SPISP_MODE_I2C 3'b110
`define SPISP_MODE_NONE 3'b111

// half periods of the divided master clock, in ref_clk cycles
`define SPISP_DIV4_HALF 6'd2
`define SPISP_DIV16_HALF 6'd8
`define SPISP_DIV64_HALF 6'd32

// transfer length and bus responses
`define SPISP_XFER_BITS 4'd8
`define SPISP_RESP_OKAY 2'b00
`define SPISP_RESP_SLVERR 2'b10

`endif

// ===== spisp_sync.v
`timescale 1ns/100ps
module spisp_sync #(
    parameter WIDTH = 4
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// two stage synchroniser; only the second stage is visible outside
always @(posedge ref_clk) begin
    if (sys_rst) begin
        meta <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule // spisp_sync

// ===== spisp_asserts.sv
`timescale 1ns/100ps
module spisp_asserts (
    input wire ref_clk,
    input wire sys_rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire sck_out,
    input wire sck_oe,
    input wire ss_n_out,
    input wire ss_n_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    reg [4:0] tog_cnt;
    reg sck_d;
    // count master clock toggles inside one select frame
    always @(posedge ref_clk) begin
        sck_d <= sck_out;
        if (sys_rst || ss_n_out)
            tog_cnt <= 5'h00;
        else if (sck_out != sck_d)
            tog_cnt <= tog_cnt + 5'h01;
    end
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence clk_quiet;
        $stable(sck_out) ##1 $stable(sck_out);
    endsequence
    wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not on time");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    sel_master_a: assert property (ss_n_oe |-> sck_oe)
        else $error("select driven outside master mode");
    frame_len_a: assert property ($rose(ss_n_out) && sck_oe |-> tog_cnt == 5'd16)
        else $error("frame clock count wrong");
    lead_time_a: assert property ($fell(ss_n_out) && sck_oe |-> clk_quiet)
        else $error("clock moved before select settled");
endmodule // spisp_asserts

bind spisp_top spisp_asserts u_chk (
    .ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sck_out, .sck_oe, .ss_n_out, .ss_n_oe
);

// ===== spisp_slave_model.sv
`timescale 1ns/100ps
module spisp_slave_model (
    input wire sck,
    input wire ss_n,
    input wire mosi,
    input wire idle_low,
    input wire cap_edge,
    input wire msb,
    input wire [7:0] tx,
    output reg miso = 1'b0,
    output reg [7:0] rx = 8'h00,
    output reg [3:0] caps = 4'h0
);
    // select opens a frame with the first bit already on the line
    always @(negedge ss_n) begin
        caps = 4'h0;
        miso = msb ? tx[7] : tx[0];
    end
    // released line flips so a stale bit never looks valid
    always @(posedge ss_n)
        miso = ~miso;
    // capture on the chosen edge, launch the next bit on the other
    always @(sck) begin
        if (!ss_n && sck == (idle_low == cap_edge)) begin
            rx = msb ? {rx[6:0], mosi} : {mosi, rx[7:1]};
            caps = caps + 4'h1;
        end else if (!ss_n && caps != 4'h0 && caps < 4'h8) begin
            miso = msb ? tx[3'd7 - caps[2:0]] : tx[caps[2:0]];
        end
    end
endmodule // spisp_slave_model

// ===== spisp_tb_top.sv
`timescale 1ns/100ps
`include "spisp_defines.vh"
module spisp_tb_top;
    localparam [7:0] uc_a = `SPISP_OFF_UNIT_CTRL;
    localparam [7:0] sc_a = `SPISP_OFF_SPI_CTRL;
    localparam [7:0] sd_a = `SPISP_OFF_SHIFT_DATA;
    reg ref_clk = 1'b0, sys_rst = 1'b1;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    // answer readies stay up, so back to back calls never drive them twice in one step
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire sck_out, sck_oe, sdo_out, sdo_oe, ss_n_out, ss_n_oe, xfer_irq, m_miso;
    reg sck_tb = 1'b1, sdi_tb = 1'b0, ss_tb = 1'b1, sub_clk_in = 1'b0, timer_match = 1'b0;
    reg m_idle = 1'b0, m_cap = 1'b0, m_msb = 1'b0;
    reg [7:0] m_tx = 8'h00;
    wire [7:0] m_rx;
    wire [3:0] m_caps;
    integer err_count = 0, n_checks = 0;
    reg [31:0] q;
    reg [1:0] r;
    // each wire is driven by whichever side has its enable up
    wire sck_pin = sck_oe ? sck_out : sck_tb;
    wire ss_pin = ss_n_oe ? ss_n_out : ss_tb;
    wire sdi_pin = sck_oe ? m_miso : sdi_tb;

    spisp_top #(.DIV4_HALF(6'd4), .DIV16_HALF(6'd4), .DIV64_HALF(6'd8)) uut (
        .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in(sck_pin),
        .sck_out, .sck_oe, .sdi_in(sdi_pin), .sdo_out, .sdo_oe, .ss_n_in(ss_pin),
        .ss_n_out, .ss_n_oe, .sub_clk_in, .timer_match, .xfer_irq);
    spisp_slave_model u_slv (.sck(sck_pin), .ss_n(ss_pin), .mosi(sdo_out),
        .idle_low(m_idle), .cap_edge(m_cap), .msb(m_msb), .tx(m_tx), .miso(m_miso),
        .rx(m_rx), .caps(m_caps));

    // 40 mhz system clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task complete_run;
        begin
            if (err_count == 0 && n_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one register access; channels released as each is taken
    task acc(input wr, input [7:0] a, input [7:0] d);
        integer i;
        begin
            if (wr) begin
                s_axi_awaddr <= a;
                s_axi_wdata <= {24'h000000, d};
                s_axi_awvalid <= 1'b1;
                s_axi_wvalid <= 1'b1;
            end else begin
                s_axi_araddr <= a;
                s_axi_arvalid <= 1'b1;
            end
            for (i = 0; i < 64; i = i + 1) begin
                @(posedge ref_clk);
                if (s_axi_awvalid && s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_arvalid && s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
                    q = s_axi_rdata;
                    r = wr ? s_axi_bresp : s_axi_rresp;
                    i = 99;
                end
            end
            if (i != 100) begin
                chk(32'h0, 32'h1);
                complete_run;
            end
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        acc(1'b1, a, d);
    endtask

    task rd_chk(input [7:0] a, input [31:0] exp);
        begin
            acc(1'b0, a, 8'h00);
            chk(q, exp);
        end
    endtask

    // reset values, spare bits, flags software cannot set, unmapped slot
    task t_regs;
        begin
            rd_chk(uc_a, 32'he0);
            rd_chk(sc_a, 32'h00);
            wr(sc_a, 8'hc3);
            chk(r, 2'b00);
            rd_chk(sc_a, 32'hc0);
            acc(1'b0, 8'h0c, 8'h00);
            chk(q, 32'h0);
            chk(r, 2'b10);
            acc(1'b1, 8'h0c, 8'h00);
            chk(r, 2'b10);
            wr(sc_a, 8'h00);
        end
    endtask

    // one master byte; optional second write lands mid-frame
    task t_master(input [2:0] md, input il, input ce, input ms, input [7:0] tx,
        input [7:0] stx, input col);
        reg [7:0] cfg;
        integer i;
        begin
            cfg = {2'b00, il, ce, ms, 3'b100};
            m_idle <= il;
            m_cap <= ce;
            m_msb <= ms;
            m_tx <= stx;
            wr(uc_a, {md, 5'b00010});
            wr(sc_a, cfg);
            cyc(2);
            chk({sck_out, ss_n_oe}, {!il, 1'b1});
            wr(sd_a, tx);
            if (col)
                wr(sd_a, ~tx);
            i = 0;
            // external half periods of four cycles; data in passes two flops,
            // so shorter halves would capture a stale bit
            while (!xfer_irq && i < 4000) begin
                timer_match <= (md == 3'b100) && (i % 4 == 1);
                if (md == 3'b011 && i % 4 == 1)
                    sub_clk_in <= !sub_clk_in;
                @(posedge ref_clk);
                i = i + 1;
            end
            chk(i < 4000, 1'b1);
            if (i >= 4000)
                complete_run;
            cyc(3);
            timer_match <= 1'b0;
            chk(m_rx, tx);
            chk(m_caps, 4'h8);
            chk(sck_out, !il);
            rd_chk(sd_a, stx);
            rd_chk(sc_a, cfg | {6'h00, col, 1'b1});
            wr(sc_a, cfg);
            rd_chk(sc_a, cfg);
            cyc(2);
            chk(xfer_irq, 1'b0);
        end
    endtask

    // bench acts as outside master: idle high, capture on falling, msb first
    task t_slave(input integer nb, input [7:0] mosi, input [7:0] stx);
        integer i;
        begin
            wr(uc_a, 8'ha2);
            wr(sc_a, 8'h1c);
            wr(sd_a, stx);
            ss_tb <= 1'b0;
            for (i = 0; i < nb; i = i + 1) begin
                sdi_tb <= mosi[7 - i];
                cyc(4);
                sck_tb <= 1'b0;
                cyc(3);
                chk(sdo_out, stx[7 - i]);
                cyc(1);
                sck_tb <= 1'b1;
            end
            cyc(4);
            ss_tb <= 1'b1;
            sdi_tb <= ~sdi_tb;
            cyc(8);
            if (nb == 8)
                rd_chk(sd_a, mosi);
            rd_chk(uc_a, (nb == 8) ? 32'ha2 : 32'ha3);
            rd_chk(sc_a, 32'h1d);
            wr(uc_a, 8'ha2);
            wr(sc_a, 8'h1c);
        end
    endtask

    // software incomplete flag, select enable, disable and idle mode
    task t_misc;
        begin
            wr(uc_a, 8'h03);
            rd_chk(sc_a, 32'h1c);
            wr(sc_a, 8'h18);
            cyc(2);
            chk({sck_oe, ss_n_oe}, 2'b10);
            wr(uc_a, 8'h00);
            cyc(2);
            chk({sck_oe, sdo_oe, ss_n_oe}, 3'b000);
            rd_chk(sc_a, 32'h18);
            wr(uc_a, 8'he2);
            cyc(2);
            chk({sck_oe, sdo_oe}, 2'b00);
        end
    endtask

    // main sequence
    initial begin
        cyc(8);
        sys_rst <= 1'b0;
        cyc(1);
        t_regs;
        t_master(3'b000, 1'b0, 1'b0, 1'b1, 8'ha5, 8'h3c, 1'b1);
        t_master(3'b001, 1'b0, 1'b1, 1'b0, 8'h96, 8'hc3, 1'b0);
        t_master(3'b010, 1'b1, 1'b0, 1'b1, 8'h81, 8'h7e, 1'b0);
        t_master(3'b000, 1'b1, 1'b1, 1'b0, 8'h01, 8'h80, 1'b0);
        t_master(3'b100, 1'b0, 1'b0, 1'b1, 8'h5c, 8'ha3, 1'b0);
        t_master(3'b011, 1'b1, 1'b0, 1'b0, 8'h3a, 8'hc5, 1'b0);
        t_slave(8, 8'h5a, 8'hc6);
        t_slave(3, 8'he7, 8'h2b);
        t_misc;
        complete_run;
    end
endmodule // spisp_tb_top
